// file: src/blo_ctrl.sv
// black level servo, offset, filter and clock control logic
// Summary of operation
// - bits 3:1 of bandwidth register pick one of eight corners; bit 0 ignored.
// - upper nibble selects peaking; zero disables boost.
// - loop-disable bit zero runs servo; one gives DAC to manual registers.
// - servo on: offset register is a digital add to ADC output.
// - servo off: DAC is offset register high bits plus shared low bits.
// - range bit halves DAC swing in both modes; default spans +-127 LSB.
// - range bit set gives eighth LSB weight, else quarter LSB.
// - servo triggers once per line after sync trailing edge; gated while coasting.
// - measurement starts after start-pixel count following trailing edge.
// - then averages pixel-width-selected pixels into the accumulator.
// - accumulates over selected line count, then derives new 10-bit DAC.
// - pixel clock equals sync rate times line total.
// - sixty-four sampling phase positions chosen by phase register.
// - sync transitions within 100 ns of an accepted one are ignored.
// - three channels each produce an 8-bit sample per pixel.
// - servo moves DAC in quarter-LSB steps, slowly.
// - offset 0x80 gives black output 0x00, or 0x80 on chroma in YUV.
`timescale 1ns/100ps
`default_nettype none
module blo_ctrl
    import blo_pkg::*;
#(
    parameter int PIX_W = 8
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [7:0]        addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [7:0]        rdata,
    input  wire logic              pix_en,
    input  wire logic              hsync_in,
    input  wire logic              coasting,
    input  wire logic              yuv_mode,
    input  wire blo_pix_type       adc_in,
    output blo_pix_type            pix_out,
    output logic      [29:0]       dac_code,
    output logic                   dac_half_range,
    output logic      [2:0]        bw_select,
    output logic      [3:0]        peak_select,
    output logic      [15:0]       line_total_pixels,
    output logic      [5:0]        phase_select,
    output logic      [2:0]        slicer_code,
    output logic                   hsync_clean
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  off_a;
        logic [7:0]  off_b;
        logic [7:0]  off_c;
        logic [7:0]  off_low;
        logic [7:0]  bw_peak;
        logic [7:0]  lt_a;
        logic [7:0]  lt_b;
        logic [7:0]  phase;
        logic [7:0]  st_a;
        logic [7:0]  st_b;
        logic [7:0]  cfg;
        logic [7:0]  in_cfg;
        logic [2:0]  slice;
        logic [7:0]  rdata;
        logic        hs_f;
        logic        hs_prev;
        logic [7:0]  glitch;
        blo_sv_type  sv;
        logic [15:0] cnt;
        logic [35:0] pix_sum;      // three 12-bit sums, room for 16 pixels
        logic [44:0] acc_sum;      // three 15-bit sums, room for 128 lines
        logic [7:0]  lines;
        logic [29:0] dac;
        blo_pix_type pix;
        logic        fire;
    } blo_state_type;

    blo_state_type s_r;
    blo_state_type s_nxt;

    // saturating add of a signed offset to an 8-bit sample
    function automatic logic [7:0] sat_add(input logic [7:0] smp, input logic [7:0] off);
        logic signed [10:0] sum;
        sum = $signed({3'b000, smp}) + $signed({3'b000, off}) - 11'sd128;
        if (sum < 0) begin
            sat_add = 8'h00;
        end else if (sum > 11'sd255) begin
            sat_add = 8'hff;
        end else begin
            sat_add = sum[7:0];
        end
    endfunction : sat_add

    // one quarter-LSB servo step toward the black target, clamped to 10 bits
    function automatic logic [9:0] servo_step(input logic [9:0] cur, input logic [7:0] avg,
                                              input logic [7:0] tgt);
        if (avg > tgt && cur != 10'h000) begin
            servo_step = cur - 10'd1;
        end else if (avg < tgt && cur != 10'h3ff) begin
            servo_step = cur + 10'd1;
        end else begin
            servo_step = cur;
        end
    endfunction : servo_step

    logic [7:0] pix_cnt;
    logic [7:0] line_cnt;
    logic [2:0] pix_sh;
    logic [2:0] line_sh;
    logic       loop_off;
    logic       trail;
    logic [7:0] avg_a;
    logic [7:0] avg_b;
    logic [7:0] avg_c;
    logic [7:0] tgt_ac;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt    = s_r;
        loop_off = s_r.cfg[LOOP_OFF_BIT];
        pix_sh   = 3'd1 + {1'b0, s_r.cfg[PIXW_LSB +: 2]};        // 2..16 pixels
        pix_cnt  = 8'd1 << pix_sh;
        line_sh  = s_r.cfg[LINES_LSB +: 3];                       // 1..128 lines
        line_cnt = 8'd1 << line_sh;
        trail    = 1'b0;
        avg_a    = 8'h00;
        avg_b    = 8'h00;
        avg_c    = 8'h00;
        tgt_ac   = yuv_mode ? OUT_MID : OUT_BLACK;
        s_nxt.fire  = 1'b0;
        s_nxt.rdata = 8'h00;
        // register bus
        if (wr) begin
            unique case (addr)
                REG_OFFSET_CH_A:  s_nxt.off_a   = wdata;
                REG_OFFSET_CH_B:  s_nxt.off_b   = wdata;
                REG_OFFSET_CH_C:  s_nxt.off_c   = wdata;
                REG_OFFSET_LOW:   s_nxt.off_low = wdata;
                REG_BW_PEAK:      s_nxt.bw_peak = wdata;
                REG_LINE_TOTAL_A: s_nxt.lt_a    = wdata;
                REG_LINE_TOTAL_B: s_nxt.lt_b    = wdata;
                REG_PHASE:        s_nxt.phase   = wdata;
                REG_START_A:      s_nxt.st_a    = wdata;
                REG_START_B:      s_nxt.st_b    = wdata;
                REG_SERVO_CFG:    s_nxt.cfg     = wdata;
                REG_INPUT_CFG:    s_nxt.in_cfg  = wdata;
                REG_SLICER:       s_nxt.slice   = wdata[2:0];
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                REG_OFFSET_CH_A:  s_nxt.rdata = s_r.off_a;
                REG_OFFSET_CH_B:  s_nxt.rdata = s_r.off_b;
                REG_OFFSET_CH_C:  s_nxt.rdata = s_r.off_c;
                REG_OFFSET_LOW:   s_nxt.rdata = s_r.off_low;
                REG_BW_PEAK:      s_nxt.rdata = s_r.bw_peak;
                REG_LINE_TOTAL_A: s_nxt.rdata = s_r.lt_a;
                REG_LINE_TOTAL_B: s_nxt.rdata = s_r.lt_b;
                REG_PHASE:        s_nxt.rdata = s_r.phase;
                REG_START_A:      s_nxt.rdata = s_r.st_a;
                REG_START_B:      s_nxt.rdata = s_r.st_b;
                REG_SERVO_CFG:    s_nxt.rdata = s_r.cfg;
                REG_INPUT_CFG:    s_nxt.rdata = s_r.in_cfg;
                REG_SLICER:       s_nxt.rdata = {5'h00, s_r.slice};
                REG_DAC_A:        s_nxt.rdata = s_r.dac[9:2];
                REG_DAC_B:        s_nxt.rdata = s_r.dac[19:12];
                REG_DAC_C:        s_nxt.rdata = s_r.dac[29:22];
                REG_DAC_LOW:      s_nxt.rdata = {2'b00, s_r.dac[21:20], s_r.dac[11:10],
                                                 s_r.dac[1:0]};
                REG_STATUS:       s_nxt.rdata = {5'h00, s_r.sv};
                default:          s_nxt.rdata = 8'h00;
            endcase
        end
        // sync glitch filter: lock out for the glitch window after a change
        if (s_r.glitch != 8'h00) begin
            s_nxt.glitch = s_r.glitch - 8'd1;
        end else if (hsync_in != s_r.hs_f) begin
            s_nxt.hs_f   = hsync_in;
            s_nxt.glitch = 8'(GLITCH_CYC - 1);
        end
        s_nxt.hs_prev = s_r.hs_f;
        trail = s_r.hs_prev & ~s_r.hs_f;
        // offset samples when the servo runs, raw samples in manual mode, one per pixel per channel
        if (pix_en) begin
            if (!loop_off) begin
                s_nxt.pix.a = sat_add(adc_in.a, s_r.off_a);
                s_nxt.pix.b = sat_add(adc_in.b, s_r.off_b);
                s_nxt.pix.c = sat_add(adc_in.c, s_r.off_c);
            end else begin
                s_nxt.pix = adc_in;
            end
        end
        // servo sequencer
        unique case (s_r.sv)
            SV_IDLE: begin
                if (trail && !loop_off && (s_r.in_cfg[COAST_GATE_BIT] || !coasting)) begin
                    s_nxt.sv      = SV_DELAY;
                    s_nxt.cnt     = {s_r.st_b, s_r.st_a};
                    s_nxt.pix_sum = '0;
                end
            end
            SV_DELAY: begin
                if (loop_off) begin
                    s_nxt.sv = SV_IDLE;
                end else if (pix_en) begin
                    if (s_r.cnt == 16'h0000) begin
                        s_nxt.sv  = SV_MEAS;
                        s_nxt.cnt = {8'h00, pix_cnt};
                    end else begin
                        s_nxt.cnt = s_r.cnt - 16'd1;
                    end
                end
            end
            SV_MEAS: begin
                if (loop_off) begin
                    s_nxt.sv = SV_IDLE;
                end else if (pix_en) begin
                    s_nxt.pix_sum[11:0]  = s_r.pix_sum[11:0] + {4'h0, adc_in.a};
                    s_nxt.pix_sum[23:12] = s_r.pix_sum[23:12] + {4'h0, adc_in.b};
                    s_nxt.pix_sum[35:24] = s_r.pix_sum[35:24] + {4'h0, adc_in.c};
                    s_nxt.cnt = s_r.cnt - 16'd1;
                    if (s_r.cnt == 16'h0001) begin
                        s_nxt.sv   = SV_IDLE;
                        s_nxt.fire = 1'b1;
                    end
                end
            end
            default: s_nxt.sv = SV_IDLE;
        endcase
        // fold the line average into the accumulator; step the DAC after N lines
        if (s_r.fire) begin
            avg_a = 8'(s_r.pix_sum[11:0] >> pix_sh);
            avg_b = 8'(s_r.pix_sum[23:12] >> pix_sh);
            avg_c = 8'(s_r.pix_sum[35:24] >> pix_sh);
            s_nxt.acc_sum[14:0]  = s_r.acc_sum[14:0] + {7'h00, avg_a};
            s_nxt.acc_sum[29:15] = s_r.acc_sum[29:15] + {7'h00, avg_b};
            s_nxt.acc_sum[44:30] = s_r.acc_sum[44:30] + {7'h00, avg_c};
            s_nxt.lines = s_r.lines + 8'd1;
            if (s_r.lines + 8'd1 >= line_cnt) begin
                avg_a = 8'(({7'h00, avg_a} + s_r.acc_sum[14:0]) >> line_sh);
                avg_b = 8'(({7'h00, avg_b} + s_r.acc_sum[29:15]) >> line_sh);
                avg_c = 8'(({7'h00, avg_c} + s_r.acc_sum[44:30]) >> line_sh);
                s_nxt.dac[9:0]   = servo_step(s_r.dac[9:0], avg_a, tgt_ac);
                s_nxt.dac[19:10] = servo_step(s_r.dac[19:10], avg_b, OUT_BLACK);
                s_nxt.dac[29:20] = servo_step(s_r.dac[29:20], avg_c, tgt_ac);
                s_nxt.acc_sum = '0;
                s_nxt.lines   = 8'h00;
            end
        end
        // manual mode hands the DAC to the registers
        if (loop_off) begin
            s_nxt.dac = {s_r.off_c, s_r.off_low[LOW_BITS_LSB +: 2],
                         s_r.off_b, s_r.off_low[LOW_BITS_LSB +: 2],
                         s_r.off_a, s_r.off_low[LOW_BITS_LSB +: 2]};
            s_nxt.acc_sum = '0;
            s_nxt.lines   = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_r         <= '0;
            s_r.off_a   <= RST_OFFSET;
            s_r.off_b   <= RST_OFFSET;
            s_r.off_c   <= RST_OFFSET;
            s_r.bw_peak <= RST_BW_PEAK;
            s_r.sv      <= SV_IDLE;
            s_r.dac     <= {DAC_MID, DAC_MID, DAC_MID};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from state flops
    // ------------------------------------------------------------
    assign rdata             = s_r.rdata;
    assign pix_out           = s_r.pix;
    assign dac_code          = s_r.dac;
    assign dac_half_range    = s_r.off_low[RANGE_BIT];
    assign bw_select         = s_r.bw_peak[BW_LSB +: 3];
    assign peak_select       = s_r.bw_peak[PEAK_LSB +: 4];
    assign line_total_pixels = {s_r.lt_b, s_r.lt_a};
    assign phase_select      = s_r.phase[5:0];
    assign slicer_code       = s_r.slice;
    assign hsync_clean       = s_r.hs_f;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    manual_dac_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.cfg[0] && !$past(wr) |-> ##1
            dac_code[9:0] == {$past(s_r.off_a), $past(s_r.off_low[3:2])})
        else $error("manual dac code mismatch");
    glitch_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(hsync_clean) |=> $stable(hsync_clean))
        else $error("sync changed inside glitch window");
    servo_trig_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.sv == SV_IDLE && trail && !s_r.cfg[0] && !s_r.in_cfg[5] && coasting
            |=> s_r.sv == SV_IDLE)
        else $error("servo started while coasting");
    dac_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        !s_r.cfg[0] && !$past(s_r.cfg[0]) |-> (dac_code[9:0] - $past(dac_code[9:0]) <= 10'd1)
            || ($past(dac_code[9:0]) - dac_code[9:0] <= 10'd1))
        else $error("servo dac jumped");
    dac_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !s_r.fire && !s_r.cfg[0] |=> $stable(dac_code))
        else $error("dac moved without a servo update");
    sat_add_a: assert property (@(posedge clk) disable iff (!reset_n)
        pix_en && !s_r.cfg[0] && adc_in.a == 8'hff && s_r.off_a >= 8'h80 |=> pix_out.a == 8'hff)
        else $error("offset sample wrapped");
    bw_field_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr && addr == REG_BW_PEAK
            |=> bw_select == $past(wdata[3:1]) && peak_select == $past(wdata[7:4]))
        else $error("bandwidth field not applied");
    start_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_r.sv == SV_DELAY && s_r.cnt != 16'h0000 && !s_r.cfg[0] |=> s_r.sv != SV_MEAS)
        else $error("measurement began before start delay");

endmodule : blo_ctrl
`default_nettype wire

// file: src/blo_pkg.sv
// package: register map, field layout, reset values and timing for the black level block
package blo_pkg;
    // register offsets
    localparam logic [7:0] REG_OFFSET_CH_A   = 8'h09;
    localparam logic [7:0] REG_OFFSET_CH_B   = 8'h0a;
    localparam logic [7:0] REG_OFFSET_CH_C   = 8'h0b;
    localparam logic [7:0] REG_OFFSET_LOW    = 8'h0c;
    localparam logic [7:0] REG_BW_PEAK       = 8'h0d;
    localparam logic [7:0] REG_LINE_TOTAL_A  = 8'h0e;
    localparam logic [7:0] REG_LINE_TOTAL_B  = 8'h0f;
    localparam logic [7:0] REG_PHASE         = 8'h10;
    localparam logic [7:0] REG_START_A       = 8'h14;
    localparam logic [7:0] REG_START_B       = 8'h15;
    localparam logic [7:0] REG_SERVO_CFG     = 8'h17;
    localparam logic [7:0] REG_INPUT_CFG     = 8'h05;
    localparam logic [7:0] REG_SLICER        = 8'h20;
    localparam logic [7:0] REG_DAC_A         = 8'h30;
    localparam logic [7:0] REG_DAC_B         = 8'h31;
    localparam logic [7:0] REG_DAC_C         = 8'h32;
    localparam logic [7:0] REG_DAC_LOW       = 8'h33;
    localparam logic [7:0] REG_STATUS        = 8'h34;
    // field positions
    localparam int RANGE_BIT      = 0;
    localparam int LOW_BITS_LSB   = 2;
    localparam int BW_LSB         = 1;
    localparam int PEAK_LSB       = 4;
    localparam int LOOP_OFF_BIT   = 0;
    localparam int PIXW_LSB       = 2;
    localparam int LINES_LSB      = 4;
    localparam int COAST_GATE_BIT = 5;
    // reset values and servo targets
    localparam logic [7:0] RST_OFFSET    = 8'h80;
    localparam logic [7:0] RST_BW_PEAK   = 8'h0e;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [9:0] DAC_MID       = 10'h200;
    localparam logic [7:0] OUT_BLACK     = 8'h00;
    localparam logic [7:0] OUT_MID       = 8'h80;
    // timing
    localparam int CLK_MHZ          = 20;
    localparam int GLITCH_NS        = 100;
    localparam int GLITCH_CYC_RAW   = (GLITCH_NS * CLK_MHZ) / 1000;
    localparam int GLITCH_CYC       = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
    localparam int PHASE_STEPS      = 64;
    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } blo_bus_type;
    // three 8-bit samples
    typedef struct packed {
        logic [7:0] c;
        logic [7:0] b;
        logic [7:0] a;
    } blo_pix_type;
    // servo states
    typedef enum logic [2:0] {
        SV_IDLE  = 3'b001,
        SV_DELAY = 3'b010,
        SV_MEAS  = 3'b100
    } blo_sv_type;
endpackage : blo_pkg

// file: dv/blo_src_model.sv
// source model: sync level, pixel enable and flat black-level samples
`timescale 1ns/100ps
`default_nettype none
module blo_src_model
    import blo_pkg::*;
#(
    parameter int LINE_LEN = 48,
    parameter int SYNC_LEN = 6
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       start,
    input  wire logic [7:0] n_lines,
    input  wire logic [7:0] level,
    input  wire logic       glitch,
    output logic            hsync_in,
    output logic            pix_en,
    output blo_pix_type     adc_in,
    output logic            busy
);
    logic [7:0] left_r;
    logic [7:0] pos_r;

    // ------------------------------------------------------------
    // line generator
    // ------------------------------------------------------------
    // sync high at line start, optional one-cycle ring just after its fall
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            left_r   <= 8'h00;
            pos_r    <= 8'h00;
            busy     <= 1'b0;
            hsync_in <= 1'b0;
            pix_en   <= 1'b0;
        end else begin
            pix_en <= 1'b1;
            if (start && !busy) begin
                left_r <= n_lines;
                pos_r  <= 8'h00;
                busy   <= (n_lines != 8'h00);
            end else if (busy) begin
                hsync_in <= (int'(pos_r) < SYNC_LEN) || (glitch && int'(pos_r) == SYNC_LEN + 1);
                if (int'(pos_r) == LINE_LEN - 1) begin
                    pos_r  <= 8'h00;
                    left_r <= left_r - 8'h01;
                    busy   <= (left_r != 8'h01);
                end else begin
                    pos_r <= pos_r + 8'h01;
                end
            end else begin
                hsync_in <= 1'b0;
            end
        end
    end

    // same black level on all three channels
    always_ff @(posedge clk) begin
        adc_in <= {level, level, level};
    end
endmodule : blo_src_model
`default_nettype wire

// file: dv/blo_ctrl_tb.sv
// testbench for the black level control block
`timescale 1ns/100ps
`default_nettype none
module blo_ctrl_tb
    import blo_pkg::*;
;
    logic        clk, reset_n, wr, rd, coasting, yuv_mode, start, glitch, busy, hs_q;
    logic [7:0]  addr, wdata, rdata, n_lines, level;
    logic        pix_en, hsync_in, dac_half_range, hsync_clean;
    blo_pix_type adc_in, pix_out;
    logic [29:0] dac_code;
    logic [2:0]  bw_select, slicer_code;
    logic [3:0]  peak_select;
    logic [15:0] line_total_pixels;
    logic [5:0]  phase_select;
    int          mismatches = 0, n_compared = 0, n_rise = 0;

    blo_ctrl u_blo_ctrl (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pix_en(pix_en), .hsync_in(hsync_in), .coasting(coasting),
        .yuv_mode(yuv_mode), .adc_in(adc_in), .pix_out(pix_out), .dac_code(dac_code),
        .dac_half_range(dac_half_range), .bw_select(bw_select), .peak_select(peak_select),
        .line_total_pixels(line_total_pixels), .phase_select(phase_select),
        .slicer_code(slicer_code), .hsync_clean(hsync_clean));
    blo_src_model u_blo_src_model (.clk(clk), .reset_n(reset_n), .start(start),
        .n_lines(n_lines), .level(level), .glitch(glitch), .hsync_in(hsync_in),
        .pix_en(pix_en), .adc_in(adc_in), .busy(busy));

    // ------------------------------------------------------------
    // clock, sync edge monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        hs_q <= hsync_clean;
        if (hsync_clean === 1'b1 && hs_q === 1'b0) n_rise <= n_rise + 1;
    end
    initial begin
        repeat (20000) @(posedge clk);
        $display("unexpected at %0t: watchdog expired", $time);
        mismatches++;
        stop_test();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_val
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk_val(32'(rdata), 32'(exp), "register read");
    endtask : chk_reg
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask : settle
    task automatic send_lines(input logic [7:0] k, input int exp_rise);
        int r0;
        r0 = n_rise;
        @(posedge clk);
        n_lines <= k;
        start   <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < 4000 && (busy !== 1'b0 || i < 2); i++) @(negedge clk);
        chk_val(32'(busy), 32'h0, "source model idle");
        repeat (10) @(negedge clk);
        chk_val(32'(n_rise - r0), 32'(exp_rise), "accepted sync pulses");
    endtask : send_lines
    // expected digital offset result, saturated to 8 bits
    function automatic logic [7:0] sat_off(input logic [7:0] s, input logic [7:0] o);
        int v;
        v = int'(s) + int'(o) - 128;
        return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
    endfunction : sat_off

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, wr, rd, coasting, yuv_mode, start, glitch} = 7'h00;
        {addr, wdata, n_lines, level} = 32'h0000_0000;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        settle();
        chk_val(32'(dac_code), 32'({3{DAC_MID}}), "dac after reset");
        chk_val(32'(bw_select), 32'h7, "bandwidth after reset");
        chk_reg(REG_BW_PEAK, RST_BW_PEAK);
        chk_reg(REG_OFFSET_CH_A, RST_OFFSET);
        chk_val(32'(pix_out), 32'h0, "black output at mid offset");
        // every bandwidth and peaking code, bit zero set and ignored
        for (int i = 0; i < 16; i++) begin
            wr_reg(REG_BW_PEAK, {4'(i), 3'(i), 1'b1});
            settle();
            chk_val(32'(bw_select), 32'(i % 8), "bandwidth select");
            chk_val(32'(peak_select), 32'(i), "peaking select");
        end
        wr_reg(REG_LINE_TOTAL_A, 8'h34);
        wr_reg(REG_LINE_TOTAL_B, 8'h12);
        wr_reg(REG_PHASE, 8'hff);
        wr_reg(REG_SLICER, 8'h01);
        settle();
        chk_val(32'(line_total_pixels), 32'h1234, "line total");
        chk_val(32'(phase_select), 32'(PHASE_STEPS - 1), "phase select");
        chk_val(32'(slicer_code), 32'h1, "slicer rising");
        wr_reg(REG_SLICER, 8'h06);
        settle();
        chk_val(32'(slicer_code), 32'h6, "slicer falling");
        // servo: two pixels, two lines per step, black above target
        @(posedge clk);
        level <= 8'h10;
        wr_reg(REG_START_A, 8'h02);
        wr_reg(REG_START_B, 8'h00);
        wr_reg(REG_SERVO_CFG, 8'h10);
        send_lines(8'h01, 1);
        chk_val(32'(dac_code), 32'({3{DAC_MID}}), "dac before line count");
        send_lines(8'h01, 1);
        chk_val(32'(dac_code), 32'({3{10'h1ff}}), "dac one step");
        @(posedge clk);
        coasting <= 1'b1;
        send_lines(8'h02, 2);
        chk_val(32'(dac_code), 32'({3{10'h1ff}}), "dac held coasting");
        wr_reg(REG_INPUT_CFG, 8'h20);
        @(posedge clk);
        glitch <= 1'b1;
        send_lines(8'h02, 2);
        chk_val(32'(dac_code), 32'({3{10'h1fe}}), "dac coast gate off");
        // colour-difference channels servo toward mid scale
        @(posedge clk);
        yuv_mode <= 1'b1;
        send_lines(8'h02, 2);
        chk_val(32'(dac_code), 32'({10'h1ff, 10'h1fd, 10'h1ff}), "dac yuv targets");
        @(posedge clk);
        {glitch, coasting, yuv_mode} <= 3'b000;
        // digital offset with saturation
        wr_reg(REG_OFFSET_CH_A, 8'hff);
        wr_reg(REG_OFFSET_CH_B, 8'h00);
        wr_reg(REG_OFFSET_CH_C, 8'h80);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            level <= (i == 0) ? 8'h10 : 8'hf0;
            settle();
            chk_val(32'(pix_out), 32'({sat_off(level, 8'h80), sat_off(level, 8'h00),
                sat_off(level, 8'hff)}), "offset samples");
        end
        // manual offset control
        wr_reg(REG_SERVO_CFG, 8'h01);
        wr_reg(REG_OFFSET_CH_A, 8'h12);
        wr_reg(REG_OFFSET_CH_B, 8'h34);
        wr_reg(REG_OFFSET_CH_C, 8'h56);
        wr_reg(REG_OFFSET_LOW, 8'h0d);
        send_lines(8'h02, 2);
        chk_val(32'(dac_code), 32'({8'h56, 2'b11, 8'h34, 2'b11, 8'h12, 2'b11}),
            "manual dac");
        chk_val(32'(pix_out), 32'({3{8'hf0}}), "raw samples");
        chk_val(32'(dac_half_range), 32'h1, "half range");
        chk_reg(REG_OFFSET_LOW, 8'h0d);
        chk_reg(REG_OFFSET_CH_B, 8'h34);
        wr_reg(REG_OFFSET_LOW, 8'h00);
        settle();
        chk_val(32'(dac_half_range), 32'h0, "full range");
        chk_val(32'(dac_code[9:0]), 32'h048, "manual low bits");
        // unmapped place: write ignored, read as zero
        wr_reg(8'h01, 8'h5a);
        chk_reg(8'h01, 8'h00);
        stop_test();
    end
endmodule : blo_ctrl_tb
`default_nettype wire
